// ### rtl/acc_consts.vh
// Purpose: constants for the analog command conditioner
// Assumes: millivolt samples, 10 MHz core clock
// Notes: definitions only
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_FULL_SCALE_MV 16'sd10000
`define ACC_CLK_HZ 10000000
`define ACC_MS_PER_S 1000
`define ACC_GAIN_RESET 16'd1000
`define ACC_TC_RESET 15'd2
`define ACC_GAIN_DIV 32'sd10000000
// One hundred percent in 0.1 % units
`define ACC_PCT_UNITS 48'sd1000
`define ACC_TRIG_NONE 3'd0
`define ACC_TRIG_CH1 3'd1
`define ACC_TRIG_CH2 3'd2
`define ACC_TRIG_CH3 3'd3
`define ACC_TRIG_ALL 3'd4
`define ACC_REG_CH1_BIAS 4'h0
`define ACC_REG_CH1_DZ 4'h1
`define ACC_REG_CH1_GAIN 4'h2
`define ACC_REG_CH1_TC 4'h3
`define ACC_REG_CH1_ZD 4'h4
`define ACC_REG_CH2_BIAS 4'h5
`define ACC_REG_CH2_DZ 4'h6
`define ACC_REG_CH2_GAIN 4'h7
`define ACC_REG_CH2_TC 4'h8
`define ACC_REG_CH2_ZD 4'h9
`define ACC_REG_MODE 4'hA
`define ACC_REG_RATED 4'hB
`define ACC_REG_TRIG 4'hC
`define ACC_REG_CH1_MV 4'hD
`define ACC_REG_CH1_SPD 4'hE
`define ACC_REG_CH2_CMD 4'hF
`endif

// ### rtl/acc_conditioner.v
// Purpose: turn two millivolt sample streams into speed or torque commands
// Assumes: samples arrive from same-clock converter logic with a valid strobe
// Notes: percentages are in 0.1 % units; speed in rpm
`timescale 1ns/1ns
`include "acc_consts.vh"
module acc_conditioner #(
  parameter NCH = 2,
  parameter SW = 16,
  parameter CLK_HZ = `ACC_CLK_HZ
) (
  core_clk,
  rstn,
  clk_en,
  sample_valid,
  analog_in_ch1,
  analog_in_ch2,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  ch1_sampled_mv,
  ch1_speed_rpm,
  ch2_cmd,
  cmd_valid
);
  input wire core_clk;
  input wire rstn;
  input wire clk_en;
  input wire sample_valid;
  input wire signed [SW-1:0] analog_in_ch1;
  input wire signed [SW-1:0] analog_in_ch2;
  input wire [3:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  output reg signed [SW-1:0] ch1_sampled_mv;
  output reg signed [31:0] ch1_speed_rpm;
  output reg signed [31:0] ch2_cmd;
  output reg cmd_valid;

  // Settings, one entry per channel, except the shared rated_q and trig_q
  reg signed [15:0] bias_q [0:NCH-1];
  reg [15:0] dz_q [0:NCH-1];
  reg [15:0] gain_q [0:NCH-1];
  reg [14:0] tc_q [0:NCH-1];
  reg signed [15:0] zd_q [0:NCH-1];
  reg [NCH-1:0] torque_mode_q;
  reg [15:0] rated_q;
  reg [2:0] trig_q;
  reg [NCH-1:0] cal_pend_q;
  // Filter state keeps 16 fraction bits so slow filters still move
  reg signed [SW+15:0] filt_q [0:NCH-1];
  reg signed [31:0] pct_q [0:NCH-1];
  reg valid_q;

  wire signed [SW-1:0] raw [0:NCH-1];
  assign raw[0] = analog_in_ch1;
  assign raw[1] = analog_in_ch2;

  wire [NCH-1:0] trig_hit;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // coefficient from tc
      // alpha = 2^16 / (tc_ms * CLK_HZ / 1000) approximated by 2^(16 - shift), shift = ceil(log2(tc_cyc))
      wire [4:0] shift;
      wire [31:0] tc_cyc;
      wire signed [SW+15:0] in_ext;
      wire signed [SW+15:0] filt_d;
      wire signed [SW-1:0] filt_mv;
      wire signed [17:0] b1;
      wire signed [17:0] b2;
      wire signed [17:0] lo;
      wire signed [17:0] hi;
      wire signed [17:0] x_mv;
      wire signed [35:0] prod;
      wire signed [35:0] pct_full;
      assign tc_cyc = tc_q[g] * (CLK_HZ / `ACC_MS_PER_S);
      function [4:0] log2c;
        input [31:0] v;
        integer i;
        begin
          log2c = 5'd0;
          for (i = 0; i < 31; i = i + 1) begin
            if (v > (32'd1 << i)) begin
              log2c = i[4:0] + 5'd1;
            end
          end
        end
      endfunction
      assign shift = log2c(tc_cyc);
      assign in_ext = {raw[g], 16'h0000};
      assign filt_d = filt_q[g] + ((in_ext - filt_q[g]) >>> shift);
      assign filt_mv = filt_q[g][SW+15:16];
      assign b1 = {{2{filt_mv[SW-1]}}, filt_mv} - {{2{zd_q[g][15]}}, zd_q[g]};
      assign x_mv = {{2{filt_mv[SW-1]}}, filt_mv} - {{2{zd_q[g][15]}}, zd_q[g]};
      assign lo = {{2{bias_q[g][15]}}, bias_q[g]} - {2'b00, dz_q[g]};
      assign hi = {{2{bias_q[g][15]}}, bias_q[g]} + {2'b00, dz_q[g]};
      assign b2 = (x_mv >= lo && x_mv <= hi) ? 18'sd0 :
        b1 - {{2{bias_q[g][15]}}, bias_q[g]};
      assign prod = b2 * $signed({2'b00, gain_q[g]});
      assign pct_full = prod / `ACC_FULL_SCALE_MV;
      assign trig_hit[g] = (trig_q == `ACC_TRIG_ALL) || (trig_q == g + 1);
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          filt_q[g] <= {(SW+16){1'b0}};
          pct_q[g] <= 32'sd0;
        end else if (clk_en && sample_valid) begin
          if (tc_q[g] == 15'd0) begin
            filt_q[g] <= in_ext;
          end else begin
            filt_q[g] <= filt_d;
          end
          pct_q[g] <= pct_full[31:0];
        end
      end
    end
  endgenerate

  integer k;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < NCH; k = k + 1) begin
        bias_q[k] <= 16'sd0;
        dz_q[k] <= 16'd0;
        gain_q[k] <= `ACC_GAIN_RESET;
        tc_q[k] <= `ACC_TC_RESET;
        zd_q[k] <= 16'sd0;
      end
      torque_mode_q <= {NCH{1'b0}};
      rated_q <= 16'd0;
      trig_q <= `ACC_TRIG_NONE;
      cal_pend_q <= {NCH{1'b0}};
    end else if (clk_en) begin
      // Calibration captures the filtered value from before the next sample as the drift
      for (k = 0; k < NCH; k = k + 1) begin
        if (cal_pend_q[k] && sample_valid) begin
          zd_q[k] <= filt_q[k][SW+15:16];
          cal_pend_q[k] <= 1'b0;
        end
        if (trig_hit[k]) begin
          cal_pend_q[k] <= 1'b1;
        end
      end
      trig_q <= `ACC_TRIG_NONE;
      if (reg_wr) begin
        case (reg_addr)
          `ACC_REG_CH1_BIAS: bias_q[0] <= reg_wdata[15:0];
          `ACC_REG_CH1_DZ: dz_q[0] <= reg_wdata[15:0];
          `ACC_REG_CH1_GAIN: gain_q[0] <= reg_wdata[15:0];
          `ACC_REG_CH1_TC: tc_q[0] <= reg_wdata[14:0];
          `ACC_REG_CH1_ZD: zd_q[0] <= reg_wdata[15:0];
          `ACC_REG_CH2_BIAS: bias_q[1] <= reg_wdata[15:0];
          `ACC_REG_CH2_DZ: dz_q[1] <= reg_wdata[15:0];
          `ACC_REG_CH2_GAIN: gain_q[1] <= reg_wdata[15:0];
          `ACC_REG_CH2_TC: tc_q[1] <= reg_wdata[14:0];
          `ACC_REG_CH2_ZD: zd_q[1] <= reg_wdata[15:0];
          `ACC_REG_MODE: torque_mode_q <= reg_wdata[NCH-1:0];
          `ACC_REG_RATED: rated_q <= reg_wdata[15:0];
          `ACC_REG_TRIG: trig_q <= reg_wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Outputs: torque mode passes the percent, speed mode scales by rated
  wire signed [47:0] spd0;
  wire signed [47:0] spd1;
  assign spd0 = pct_q[0] * $signed({16'h0000, rated_q}) / `ACC_PCT_UNITS;
  assign spd1 = pct_q[1] * $signed({16'h0000, rated_q}) / `ACC_PCT_UNITS;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ch1_sampled_mv <= {SW{1'b0}};
      ch1_speed_rpm <= 32'sd0;
      ch2_cmd <= 32'sd0;
      valid_q <= 1'b0;
      cmd_valid <= 1'b0;
    end else if (clk_en) begin
      ch1_sampled_mv <= filt_q[0][SW+15:16];
      valid_q <= sample_valid;
      cmd_valid <= valid_q;
      // Commands move only with cmd_valid, so a mode or rated write
      // never produces an unannounced step on the outputs
      if (valid_q) begin
        ch1_speed_rpm <= torque_mode_q[0] ? pct_q[0] : spd0[31:0];
        ch2_cmd <= torque_mode_q[1] ? pct_q[1] : spd1[31:0];
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `ACC_REG_CH1_BIAS: reg_rdata <= {{16{bias_q[0][15]}}, bias_q[0]};
          `ACC_REG_CH1_DZ: reg_rdata <= {16'h0000, dz_q[0]};
          `ACC_REG_CH1_GAIN: reg_rdata <= {16'h0000, gain_q[0]};
          `ACC_REG_CH1_TC: reg_rdata <= {17'h00000, tc_q[0]};
          `ACC_REG_CH1_ZD: reg_rdata <= {{16{zd_q[0][15]}}, zd_q[0]};
          `ACC_REG_CH2_BIAS: reg_rdata <= {{16{bias_q[1][15]}}, bias_q[1]};
          `ACC_REG_CH2_DZ: reg_rdata <= {16'h0000, dz_q[1]};
          `ACC_REG_CH2_GAIN: reg_rdata <= {16'h0000, gain_q[1]};
          `ACC_REG_CH2_TC: reg_rdata <= {17'h00000, tc_q[1]};
          `ACC_REG_CH2_ZD: reg_rdata <= {{16{zd_q[1][15]}}, zd_q[1]};
          `ACC_REG_MODE: reg_rdata <= {30'h00000000, torque_mode_q};
          `ACC_REG_RATED: reg_rdata <= {16'h0000, rated_q};
          `ACC_REG_TRIG: reg_rdata <= {30'h00000000, cal_pend_q};
          `ACC_REG_CH1_MV: reg_rdata <= {{16{ch1_sampled_mv[SW-1]}}, ch1_sampled_mv};
          `ACC_REG_CH1_SPD: reg_rdata <= ch1_speed_rpm;
          `ACC_REG_CH2_CMD: reg_rdata <= ch2_cmd;
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ### sim/acc_conditioner_sva.sv
// Purpose: port checks for acc_conditioner
// Assumes: 2-cycle sample pipeline
// Notes: bound after the module
`timescale 1ns/1ns
module acc_chk (
  input logic core_clk,
  input logic rstn,
  input logic clk_en,
  input logic sample_valid,
  input logic [3:0] reg_addr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic signed [31:0] ch1_speed_rpm,
  input logic signed [31:0] ch2_cmd,
  input logic cmd_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  vld_late_a: assert property (
    sample_valid && clk_en ##1 clk_en [*2] |-> cmd_valid) else $error("cmd_valid late");
  vld_cause_a: assert property (
    cmd_valid && $past(clk_en) && $past(clk_en, 2) |-> $past(sample_valid, 2))
    else $error("cmd_valid without sample");
  spd_hold_a: assert property (!cmd_valid |-> $stable(ch1_speed_rpm))
    else $error("speed moved");
  cmd2_hold_a: assert property (!cmd_valid |-> $stable(ch2_cmd))
    else $error("ch2 moved");
  en_freeze_a: assert property (!clk_en |=> $stable(ch1_speed_rpm) && !cmd_valid)
    else $error("not frozen");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not zero");
  rd_speed_a: assert property (
    $past(reg_rd && reg_addr == 4'hE) && !cmd_valid |-> reg_rdata == ch1_speed_rpm)
    else $error("speed readback");
  rd_ch2_a: assert property (
    $past(reg_rd && reg_addr == 4'hF) && !cmd_valid |-> reg_rdata == ch2_cmd)
    else $error("ch2 readback");
  cover property (cmd_valid);
  cover property (reg_rd && reg_addr == 4'hE);
  cover property (!clk_en);
endmodule
bind acc_conditioner acc_chk u_chk (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
  .sample_valid(sample_valid), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ch1_speed_rpm(ch1_speed_rpm), .ch2_cmd(ch2_cmd), .cmd_valid(cmd_valid));

// ### sim/acc_adc_model.sv
// Purpose: converter feeding mV samples
// Assumes: one sample each four clocks
// Notes: data lines toggle between samples
`timescale 1ns/1ns
module acc_adc_model (
  input logic core_clk,
  input logic rstn,
  input logic [15:0] mv1,
  input logic [15:0] mv2,
  output logic sample_valid,
  output logic [15:0] analog_in_ch1,
  output logic [15:0] analog_in_ch2
);
  logic [1:0] cnt_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      sample_valid <= 1'b0;
      analog_in_ch1 <= 16'h0;
      analog_in_ch2 <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      sample_valid <= cnt_q == 2'h3;
      // Junk off-sample so a stale latch shows
      analog_in_ch1 <= cnt_q == 2'h3 ? mv1 : ~analog_in_ch1;
      analog_in_ch2 <= cnt_q == 2'h3 ? mv2 : ~analog_in_ch2;
    end
  end
endmodule

// ### sim/acc_conditioner_tb.sv
// Purpose: self-checking bench for acc_conditioner
// Assumes: 0.1 % units, filters bypassed until the ch1 filter check
// Notes: values in hex
`timescale 1ns/1ns
module acc_conditioner_tb;
  logic core_clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, sv, cv;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, spd, c2;
  logic [15:0] mv1 = 16'h0, mv2 = 16'h0, a1, a2, smv;
  integer error_cnt = 0, num_checks = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  acc_adc_model adc (.core_clk(core_clk), .rstn(rstn), .mv1(mv1), .mv2(mv2),
    .sample_valid(sv), .analog_in_ch1(a1), .analog_in_ch2(a2));
  acc_conditioner uut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .sample_valid(sv),
    .analog_in_ch1(a1), .analog_in_ch2(a2), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_sampled_mv(smv),
    .ch1_speed_rpm(spd), .ch2_cmd(c2), .cmd_valid(cv));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // Three results so the one-sample-old percentage has caught up
  task run(input logic [15:0] m1, input logic [15:0] m2);
    integer i, k;
    mv1 <= m1;
    mv2 <= m2;
    for (i = 0; i < 3; i++) begin
      k = 0;
      do begin
        @(negedge core_clk);
        k++;
      end while (cv !== 1'b1 && k < 40);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1;
    rd(4'h2, 32'h3E8);
    rd(4'h3, 32'h2);
    wr(4'h3, 32'h0);
    wr(4'h8, 32'h0);
    wr(4'hB, 32'hBB8);
    wr(4'h7, 32'h1F4);
    run(16'h1388, 16'hF830);
    chk("mv", 32'h1388, {{16{smv[15]}}, smv});
    chk("spd", 32'h5DC, spd);
    chk("ch2", 32'hFFFFFED4, c2);
    rd(4'hE, 32'h5DC);
    wr(4'h0, 32'hFA0);
    wr(4'h1, 32'h320);
    run(16'h12C0, 16'hF830);
    chk("spd", 32'h0, spd);
    run(16'h1388, 16'hF830);
    chk("spd", 32'h12C, spd);
    run(16'hD8F0, 16'hF830);
    chk("spd", 32'hFFFFEF98, spd);
    @(posedge core_clk);
    clk_en <= 0;
    repeat (6) @(posedge core_clk);
    clk_en <= 1;
    wr(4'hA, 32'h3);
    run(16'h1388, 16'hF830);
    chk("spd", 32'h64, spd);
    chk("ch2", 32'hFFFFFF9C, c2);
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h0);
    wr(4'hA, 32'h0);
    run(16'h190, 16'h64);
    wr(4'hC, 32'h4);
    run(16'h190, 16'h64);
    rd(4'h4, 32'h190);
    rd(4'h9, 32'h64);
    rd(4'hC, 32'h0);
    run(16'h1518, 16'h64);
    chk("spd", 32'h5DC, spd);
    wr(4'h3, 32'h2);
    run(16'h0, 16'hC8);
    chk("mv", 32'h1517, {{16{smv[15]}}, smv});
    chk("spd", 32'h5D9, spd);
    wr(4'hC, 32'h2);
    run(16'h0, 16'hC8);
    rd(4'h9, 32'hC8);
    rd(4'h4, 32'h190);
    final_report;
  end
endmodule
